//--- saos_pkg.sv
// Shared constants, register map and state types for the set-all-ones and sleep execution block.
package saos_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses on the APB).
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_INSTR = 8'h00;  // Instruction issue register.
    localparam logic [7:0] ADDR_BANK = 8'h04;   // Bank select register.
    localparam logic [7:0] ADDR_STATUS = 8'h08; // Status and flag register.
    localparam logic [7:0] ADDR_MADDR = 8'h0C;  // Data memory window address.
    localparam logic [7:0] ADDR_MDATA = 8'h10;  // Data memory window data.
    localparam logic [7:0] ADDR_WAKE = 8'h14;   // Software wake-up strobe.

    // ----------------------------------------------------------------
    // Field positions.
    // ----------------------------------------------------------------
    localparam int INSTR_F_LSB = 0;   // Register operand f, eight bits.
    localparam int INSTR_A_BIT = 8;   // Bank-select operand bit.
    localparam int INSTR_OP_BIT = 9;  // Zero selects set-all-ones, one selects sleep.
    localparam int ST_PWRDN_BIT = 0;  // Power-down flag.
    localparam int ST_TIMEOUT_BIT = 1; // Time-out flag.
    localparam int ST_SLEEP_BIT = 2;  // Core is asleep.
    localparam int ST_BUSY_BIT = 3;   // An instruction is in flight.
    localparam int ST_ARITH_LSB = 4;  // Four arithmetic flags, software owned.
    localparam int WAKE_BIT = 0;      // Writing one wakes the core.

    // ----------------------------------------------------------------
    // Values.
    // ----------------------------------------------------------------
    localparam logic [7:0] ALL_ONES = 8'hFF;      // Value stored by set-all-ones.
    localparam logic [3:0] FAST_BANK = 4'h0;      // Bank reached when the operand bit is zero.
    localparam logic PWRDN_RST = 1'b1;            // Power-down flag after reset.
    localparam logic TIMEOUT_RST = 1'b1;          // Time-out flag after reset.
    localparam logic [3:0] BANK_RST = 4'h0;       // Bank select register after reset.
    localparam logic [3:0] ARITH_RST = 4'h0;      // Arithmetic flags after reset.
    localparam logic [11:0] MADDR_RST = 12'h000;  // Memory window address after reset.
    localparam logic [15:0] WATCHDOG_LIMIT_DEF = 16'h00FF; // Watchdog base count per postscaler step.
    localparam logic [3:0] POST_LIMIT_DEF = 4'h3;     // Postscaler steps before expiry.

    // Quarter-cycle sequence of one instruction cycle.
    typedef enum logic [2:0] {
        Q_IDLE,
        Q_DECODE,
        Q_READ,
        Q_PROCESS,
        Q_WRITE
    } saos_q_e;

    // Resolves the data-memory address from the operand bit, the bank select register and f.
    function automatic logic [11:0] saos_target(input logic a, input logic [3:0] bank, input logic [7:0] f);
        saos_target = a ? {bank, f} : {FAST_BANK, f};
    endfunction

endpackage

//--- saos_dmem.sv
// Data memory of sixteen banks of 256 bytes with one write and one registered read port.
`timescale 1ns/1ps
module saos_dmem
    import saos_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic we,
    input wire logic [11:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [11:0] raddr,
    output logic [7:0] rdata
);

    // ----------------------------------------------------------------
    // Storage.
    // ----------------------------------------------------------------
    logic [7:0] mem [0:4095]; // Byte array, contents undefined after power-up.

    // Writes land at the clock edge; no reset on the array.
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read; shows zero during reset.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= mem[raddr];
        end
    end

endmodule

//--- saos_core.sv
// Execution block for the set-all-ones and sleep instructions with an APB register slave.
//
// Notes on behaviour
// (RULE1) Set-all-ones writes FFh, flags untouched.
// (RULE2) Operand bit zero addresses the fast bank.
// (RULE3) Operand bit one uses bank select register.
// (RULE4) Sleep clears powerdown, sets timeout, clears watchdog.
// (RULE5) Sleep touches only timeout and powerdown flags.
// (RULE6) Watchdog wake-up from sleep clears TO.
// (RULE7) One cycle each; effect in fourth quarter.
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module saos_core
    import saos_pkg::*;
#(
    parameter logic [15:0] WATCHDOG_LIMIT = WATCHDOG_LIMIT_DEF,
    parameter logic [3:0] POST_LIMIT = POST_LIMIT_DEF
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic asleep
);

    // ----------------------------------------------------------------
    // State.
    // ----------------------------------------------------------------
    saos_q_e q;                    // Current quarter of the instruction cycle.
    logic cur_op;                  // Latched operation, one for sleep.
    logic cur_a;                   // Latched bank-select operand bit.
    logic [7:0] cur_f;             // Latched register operand.
    logic [3:0] bank_select_reg;   // Bank used when the operand bit is one.
    logic powerdown_flag;          // Power-down status flag.
    logic timeout_flag;            // Time-out status flag.
    logic [3:0] arith_flags;       // Arithmetic flags, written only by software.
    logic [11:0] mem_addr;         // Memory window address.
    logic [15:0] watchdog_cnt;     // Watchdog timer count.
    logic [3:0] post_cnt;          // Watchdog postscaler count.
    logic [7:0] mem_rdata;         // Memory read data at the window address.

    // ----------------------------------------------------------------
    // Bus decode.
    // ----------------------------------------------------------------
    logic busy;        // An instruction occupies the sequence.
    logic apb_done;    // Completing edge of an APB transfer.
    logic apb_wr;      // Completing write.
    logic bad_req;     // Current request is refused.
    logic do_set;      // Fourth quarter of set-all-ones.
    logic do_sleep;    // Fourth quarter of sleep.
    logic watchdog_wrap;    // Base count at its limit.
    logic watchdog_expire;  // Watchdog expiry this cycle.
    logic go;          // Accepted instruction issue.
    logic mem_we;      // Memory write strobe.
    logic [11:0] mem_waddr; // Memory write address.
    logic [7:0] mem_wdata;  // Memory write data.

    assign busy = (q != Q_IDLE);
    assign apb_done = psel && penable && pready;
    assign apb_wr = apb_done && pwrite && !pslverr;
    assign do_set = (q == Q_WRITE) && !cur_op;
    assign do_sleep = (q == Q_WRITE) && cur_op;
    assign watchdog_wrap = (watchdog_cnt == WATCHDOG_LIMIT);
    assign watchdog_expire = watchdog_wrap && (post_cnt == POST_LIMIT);
    assign go = apb_wr && (paddr == ADDR_INSTR);

    // Refusals: issue while busy or asleep, status and data writes while busy, unmapped addresses.
    always_comb begin
        bad_req = 1'b0;
        case (paddr)
            ADDR_INSTR: begin
                bad_req = pwrite && (busy || asleep);
            end
            ADDR_STATUS, ADDR_MDATA: begin
                bad_req = pwrite && busy;
            end
            ADDR_BANK, ADDR_MADDR, ADDR_WAKE: begin
                bad_req = 1'b0;
            end
            default: begin
                bad_req = 1'b1;
            end
        endcase
    end

    // One wait state: ready rises in the second access cycle with error and read data.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && bad_req;
            prdata <= 32'h0000_0000;
            if (psel && penable && !pready && !pwrite) begin
                case (paddr)
                    ADDR_BANK: prdata <= {28'h000_0000, bank_select_reg};
                    ADDR_STATUS: prdata <= {24'h00_0000, arith_flags, busy, asleep, timeout_flag, powerdown_flag};
                    ADDR_MADDR: prdata <= {20'h0_0000, mem_addr};
                    ADDR_MDATA: prdata <= {24'h00_0000, mem_rdata};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Software registers.
    // ----------------------------------------------------------------

    // Bank select, window address and arithmetic flags.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            bank_select_reg <= BANK_RST;
            mem_addr <= MADDR_RST;
            arith_flags <= ARITH_RST;
        end else if (apb_wr) begin
            if (paddr == ADDR_BANK) begin
                bank_select_reg <= pwdata[3:0];
            end
            if (paddr == ADDR_MADDR) begin
                mem_addr <= pwdata[11:0];
            end
            // Refused while busy, so neither instruction disturbs these flags.
            if (paddr == ADDR_STATUS) begin
                arith_flags <= pwdata[ST_ARITH_LSB +: 4]; // [RULE1] [RULE5]
            end
        end
    end

    // ----------------------------------------------------------------
    // Quarter-cycle sequencer.
    // ----------------------------------------------------------------

    // Steps through the four quarters of one instruction cycle.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= Q_IDLE;
        end else begin
            case (q)
                Q_IDLE: q <= go ? Q_DECODE : Q_IDLE; // [RULE7]
                Q_DECODE: q <= Q_READ;
                Q_READ: q <= Q_PROCESS;
                Q_PROCESS: q <= Q_WRITE;
                Q_WRITE: q <= Q_IDLE;
                default: q <= Q_IDLE;
            endcase
        end
    end

    // Latches the operand word when the issue is accepted.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cur_op <= 1'b0;
            cur_a <= 1'b1;
            cur_f <= 8'h00;
        end else if (go) begin
            cur_op <= pwdata[INSTR_OP_BIT];
            cur_a <= pwdata[INSTR_A_BIT];
            cur_f <= pwdata[INSTR_F_LSB +: 8];
        end
    end

    // ----------------------------------------------------------------
    // Data memory write path.
    // ----------------------------------------------------------------

    // The instruction owns the port in its fourth quarter; bus writes are refused then.
    always_comb begin
        mem_we = do_set || (apb_wr && (paddr == ADDR_MDATA)); // [RULE7]
        mem_waddr = mem_addr;
        mem_wdata = pwdata[7:0];
        if (do_set) begin
            mem_waddr = saos_target(cur_a, bank_select_reg, cur_f); // [RULE2] [RULE3]
            mem_wdata = ALL_ONES; // [RULE1]
        end
    end

    saos_dmem u_dmem (
        .clk_sys(clk_sys),
        .rst(rst),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(mem_addr),
        .rdata(mem_rdata)
    );

    // ----------------------------------------------------------------
    // Watchdog and sleep.
    // ----------------------------------------------------------------

    // Free-running watchdog; sleep clears both stages, expiry restarts them.
    always_ff @(posedge clk_sys) begin
        if (rst || do_sleep || watchdog_expire) begin
            watchdog_cnt <= 16'h0000; // [RULE4]
            post_cnt <= 4'h0;    // [RULE4]
        end else if (watchdog_wrap) begin
            watchdog_cnt <= 16'h0000;
            post_cnt <= post_cnt + 4'h1;
        end else begin
            watchdog_cnt <= watchdog_cnt + 16'h0001;
        end
    end

    // Status flags and the sleep state; sleep entry wins over a simultaneous expiry.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            powerdown_flag <= PWRDN_RST;
            timeout_flag <= TIMEOUT_RST;
            asleep <= 1'b0;
        end else if (do_sleep) begin
            powerdown_flag <= 1'b0; // [RULE4] [RULE5]
            timeout_flag <= 1'b1;   // [RULE4] [RULE5]
            asleep <= 1'b1;         // [RULE7]
        end else if (watchdog_expire) begin
            timeout_flag <= 1'b0;   // [RULE6]
            asleep <= 1'b0;
        end else if (apb_wr && (paddr == ADDR_WAKE) && pwdata[WAKE_BIT]) begin
            asleep <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Checks.
    // ----------------------------------------------------------------
    set_ones_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE1]
        do_set |-> mem_we && (mem_wdata == ALL_ONES) ##1 $stable(arith_flags))
        else $error("set-all-ones did not store all ones or flags moved");
    fast_bank_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE2]
        (do_set && !cur_a) |-> (mem_waddr == {FAST_BANK, cur_f}))
        else $error("fast bank not used when operand bit is zero");
    bank_select_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE3]
        (do_set && cur_a) |-> (mem_waddr == {bank_select_reg, cur_f}))
        else $error("bank select register not used when operand bit is one");
    sleep_entry_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE4]
        do_sleep |=> !powerdown_flag && timeout_flag && (watchdog_cnt == 16'h0000) && (post_cnt == 4'h0))
        else $error("sleep entry did not update flags or clear watchdog");
    sleep_arith_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE5]
        do_sleep |=> $stable(arith_flags) && !mem_we)
        else $error("sleep touched arithmetic flags or memory");
    watchdog_wake_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE6]
        (asleep && watchdog_expire) |=> !asleep && !timeout_flag)
        else $error("watchdog wake-up did not clear time-out flag");
    one_cycle_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE7]
        go |=> (q == Q_DECODE) ##3 (q == Q_WRITE) ##1 (q == Q_IDLE))
        else $error("instruction cycle is not four quarters");
    write_quarter_a: assert property (@(posedge clk_sys) disable iff (rst) // [RULE7]
        (busy && mem_we) |-> (q == Q_WRITE) && !cur_op)
        else $error("memory written outside the fourth quarter");

endmodule

//--- saos_tb.sv
// Self-checking testbench for the set-all-ones and sleep execution block.
`timescale 1ns/1ps
module testbench
    import saos_pkg::*;
;
    // ----------------------------------------------------------------
    // Clock, reset, bus signals and bookkeeping
    // ----------------------------------------------------------------
    localparam logic [15:0] TB_WATCHDOG = 16'h000F; // Short base count keeps the run brief.
    localparam logic [3:0] TB_POST = 4'h3; // Postscaler steps before expiry.
    localparam int WAKE_CYC = (TB_WATCHDOG + 1) * (TB_POST + 1); // Cycles from clear to expiry.
    typedef struct {logic [31:0] d; logic [31:0] m; logic e; string nm;} saos_note_s;
    logic clk_sys = 1'b0; // System clock, 200 MHz.
    logic rst = 1'b1; // Synchronous reset.
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic asleep;
    saos_note_s notes[$]; // Expected answers, oldest first.
    saos_note_s nt; // Note being compared.
    int err_count = 0;
    int n_tests = 0;
    int seed = 57997;
    int cyc = 0; // Free-running cycle count.
    int t_sleep;
    int n;
    logic [7:0] f;
    logic [3:0] bank;
    logic [3:0] arith;
    logic a;

    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;

    saos_core #(.WATCHDOG_LIMIT(TB_WATCHDOG), .POST_LIMIT(TB_POST)) u_dut (.clk_sys(clk_sys), .rst(rst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .asleep(asleep));

    // ----------------------------------------------------------------
    // Compare tasks and closing task
    // ----------------------------------------------------------------
    task automatic check_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic check_bit(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic complete_run();
        $display("Checks made: %0d, mismatches: %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One APB transfer; the expected answer is noted before the request goes out.
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic [31:0] ex,
                       input logic [31:0] m, input logic e);
        saos_note_s x;
        int k;
        x.d = ex;
        x.m = m;
        x.e = e;
        x.nm = $sformatf("addr %h", ad);
        notes.push_back(x);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            err_count++;
            $display("wrong value pready expected 1 seen %b", pready);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic e);
        apb(1'b1, ad, d, 32'h0000_0000, 32'h0000_0000, e);
    endtask

    task automatic rd(input logic [7:0] ad, input logic [31:0] ex, input logic [31:0] m, input logic e);
        apb(1'b0, ad, 32'h0000_0000, ex, m, e);
    endtask

    // Monitor: every answer takes the oldest note and is compared under its mask.
    always @(posedge clk_sys) begin
        if (pready === 1'b1) begin
            if (notes.size() == 0) begin
                err_count++;
                $display("wrong value answer expected none seen %h", prdata);
            end else begin
                nt = notes.pop_front();
                check_word({nt.nm, " data"}, nt.d & nt.m, prdata & nt.m);
                check_word({nt.nm, " error"}, {31'h0, nt.e}, {31'h0, pslverr});
            end
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        // Reset values and refused places.
        rd(ADDR_STATUS, 32'h0000_0003, 32'hFFFF_FFFF, 1'b0);
        rd(ADDR_BANK, 32'h0000_0000, 32'hFFFF_FFFF, 1'b0);
        rd(ADDR_MADDR, 32'h0000_0000, 32'hFFFF_FFFF, 1'b0);
        rd(8'h18, 32'h0000_0000, 32'h0000_0000, 1'b1);
        wr(8'h1C, 32'h0000_00FF, 1'b1);
        $display("test reset done");
        // Software flags and a nonzero bank, so the two banks never alias.
        arith = 4'($random(seed));
        bank = 4'(({$random(seed)} % 15) + 1);
        wr(ADDR_STATUS, {24'h0, arith, 4'hF}, 1'b0);
        wr(ADDR_BANK, {28'h0, bank}, 1'b0);
        for (int i = 0; i < 2; i++) begin
            a = (i == 0);
            f = 8'($random(seed));
            wr(ADDR_MADDR, {20'h0, bank, f}, 1'b0);
            wr(ADDR_MDATA, 32'h0000_005A, 1'b0);
            wr(ADDR_MADDR, {20'h0, FAST_BANK, f}, 1'b0);
            wr(ADDR_MDATA, 32'h0000_005A, 1'b0);
            wr(ADDR_INSTR, {22'h0, 1'b0, a, f}, 1'b0);
            wr(ADDR_INSTR, {22'h0, 1'b0, a, f}, 1'b1);
            rd(ADDR_STATUS, {24'h0, arith, 4'b0001}, 32'hFFFF_FFFD, 1'b0);
            wr(ADDR_MADDR, {20'h0, bank, f}, 1'b0);
            rd(ADDR_MDATA, a ? 32'h0000_00FF : 32'h0000_005A, 32'hFFFF_FFFF, 1'b0);
            wr(ADDR_MADDR, {20'h0, FAST_BANK, f}, 1'b0);
            rd(ADDR_MDATA, a ? 32'h0000_005A : 32'h0000_00FF, 32'hFFFF_FFFF, 1'b0);
            $display("test set all ones, operand bit %b done", a);
        end
        // Sleep with a watchdog wake-up.
        wr(ADDR_INSTR, 32'h0000_0200, 1'b0);
        repeat (3) @(posedge clk_sys);
        #1 check_bit("asleep before fourth quarter", 1'b0, asleep);
        @(posedge clk_sys);
        #1 check_bit("asleep at fourth quarter", 1'b1, asleep);
        t_sleep = cyc;
        rd(ADDR_STATUS, {24'h0, arith, 4'b0110}, 32'hFFFF_FFFF, 1'b0);
        wr(ADDR_INSTR, 32'h0000_0000, 1'b1);
        #1 n = 0;
        while (asleep !== 1'b0 && n < 500) begin
            @(posedge clk_sys);
            #1 n++;
        end
        check_word("watchdog wake time", 32'(WAKE_CYC), 32'(cyc - t_sleep));
        rd(ADDR_STATUS, {24'h0, arith, 4'b0000}, 32'hFFFF_FFFF, 1'b0);
        $display("test sleep with watchdog wake done");
        // Sleep with a software wake-up: the time-out flag stays set.
        wr(ADDR_INSTR, 32'h0000_0200, 1'b0);
        repeat (5) @(posedge clk_sys);
        wr(ADDR_WAKE, 32'h0000_0001, 1'b0);
        rd(ADDR_STATUS, {24'h0, arith, 4'b0010}, 32'hFFFF_FFFF, 1'b0);
        #1 check_bit("asleep after wake", 1'b0, asleep);
        $display("test sleep with software wake done");
        repeat (3) @(posedge clk_sys);
        complete_run();
    end

    // Watchdog: the whole sequence needs well under a thousand cycles.
    initial begin
        #25000;
        err_count++;
        complete_run();
    end
endmodule
